// ===== design/pae_alarm.sv
// Purpose: per-channel alarm evaluation with on/off delays and APB registers
// Assumes: measured values from same-clock logic; detector flags from pins
// Notes: standby sequence, loop burnout and rate details come in as inputs
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns

module pae_alarm (
	input wire logic clk, // 100 MHz
	input wire logic reset_n, // synchronous, active low
	input wire logic [11:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic sampleTick, // one pulse per input sample
	input wire logic signed [15:0] processValue, // measured value
	input wire logic signed [15:0] setPoint, // working set point
	input wire logic signed [15:0] remoteSetPoint, // remote set point
	input wire logic signed [15:0] hysteresis, // alarm hysteresis
	input wire logic [2:0] standbyClear, // standby released per channel
	input wire logic loopBurnout, // loop burnout detected
	input wire logic [2:0] rateAlarm, // change rate exceeded per channel
	input wire logic heaterBurnout, // heater burnout pin
	input wire logic relayFailure, // solid_state_relay failure pin
	input wire logic heaterOvercurrent, // overcurrent pin
	input wire logic hasHeaterDetect, // strap: heater detection fitted
	input wire logic hasRemoteSetPoint, // strap: remote set point fitted
	output logic [2:0] auxOutput // auxiliary outputs
);
	import pae_pkg::*;

	// ****************************************
	// configuration storage
	// ****************************************
	logic [3:0] alarmType [PAE_CHANNELS];
	logic signed [15:0] alarmValue [PAE_CHANNELS];
	pae_lim_t alarmLimit [PAE_CHANNELS];
	pae_dly_t alarmDelay [PAE_CHANNELS];
	logic [2:0] rawAlarm;
	logic [2:0] delayedAlarm;
	logic [2:0] heatSync1, heatSync2;
	logic optSync1, optSync2, rspSync1, rspSync2;
	logic [26:0] secCount;
	logic secTick;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic typeAllowed(input int ch, input logic [3:0] t, input logic rsp);
		typeAllowed = 1'b1;
		if (t == PAE_LOOP_BURN && ch != 0) typeAllowed = 1'b0;
		if ((t == PAE_RSP_HI || t == PAE_RSP_LO) && !rsp) typeAllowed = 1'b0;
	endfunction : typeAllowed

	function automatic logic [9:0] clampDelay(input logic [15:0] v);
		clampDelay = (v > 16'(PAE_DLY_MAX)) ? PAE_DLY_MAX : v[9:0];
	endfunction : clampDelay

	function automatic logic [3:0] baseType(input logic [3:0] t);
		case (t)
			PAE_BAND_SB: baseType = PAE_BAND;
			PAE_DEV_HI_SB: baseType = PAE_DEV_HI;
			PAE_DEV_LO_SB: baseType = PAE_DEV_LO;
			PAE_ABS_HI_SB: baseType = PAE_ABS_HI;
			PAE_ABS_LO_SB: baseType = PAE_ABS_LO;
			default: baseType = t;
		endcase
	endfunction : baseType

	function automatic logic isStandby(input logic [3:0] t);
		isStandby = (t == PAE_BAND_SB) || (t == PAE_DEV_HI_SB) || (t == PAE_DEV_LO_SB)
			|| (t == PAE_ABS_HI_SB) || (t == PAE_ABS_LO_SB);
	endfunction : isStandby

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			heatSync1 <= 3'h0;
			heatSync2 <= 3'h0;
			optSync1 <= 1'b0;
			optSync2 <= 1'b0;
			rspSync1 <= 1'b0;
			rspSync2 <= 1'b0;
		end else begin
			heatSync1 <= {heaterOvercurrent, relayFailure, heaterBurnout};
			heatSync2 <= heatSync1;
			optSync1 <= hasHeaterDetect;
			optSync2 <= optSync1;
			rspSync1 <= hasRemoteSetPoint;
			rspSync2 <= rspSync1;
		end
	end

	// ****************************************
	// one second tick
	// ****************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			secCount <= 27'h0;
			secTick <= 1'b0;
		end else if (secCount == 27'(PAE_SEC_CYCLES - 1)) begin
			secCount <= 27'h0;
			secTick <= 1'b1;
		end else begin
			secCount <= secCount + 27'h1;
			secTick <= 1'b0;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	logic apbAccess;
	logic [1:0] chSel;
	logic [3:0] ofs;
	logic chHit;
	assign apbAccess = psel && penable && pready;
	assign chSel = 2'(paddr[5:4]);
	assign ofs = paddr[3:0];
	assign chHit = (paddr[11:6] == 6'h0) && (chSel < 2'(PAE_CHANNELS));

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < PAE_CHANNELS; i++) begin
				alarmType[i] <= PAE_TYPE_RESET;
				alarmValue[i] <= 16'sh0;
				alarmLimit[i] <= '0;
				alarmDelay[i] <= '0;
			end
		end else if (apbAccess && pwrite && chHit) begin
			case (ofs)
				PAE_OFS_CFG: begin
					if (typeAllowed(int'(chSel), pwdata[3:0], rspSync2)) begin
						alarmType[chSel] <= (pwdata[31:4] != 28'h0) ? PAE_OFF : pwdata[3:0];
					end
				end
				PAE_OFS_VAL: alarmValue[chSel] <= pwdata[15:0];
				PAE_OFS_LIM: alarmLimit[chSel] <= {pwdata[PAE_LIM_HI_LSB +: 16], pwdata[PAE_LIM_LO_LSB +: 16]};
				PAE_OFS_DLY: alarmDelay[chSel] <= {clampDelay(pwdata[PAE_DLY_ON_LSB +: 16]),
					clampDelay(pwdata[PAE_DLY_OFF_LSB +: 16])};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (chHit) begin
				case (ofs)
					PAE_OFS_CFG: prdata <= {28'h0, alarmType[chSel]};
					PAE_OFS_VAL: prdata <= {{16{alarmValue[chSel][15]}}, alarmValue[chSel]};
					PAE_OFS_LIM: prdata <= {alarmLimit[chSel].hi, alarmLimit[chSel].lo};
					PAE_OFS_DLY: prdata <= {6'h0, alarmDelay[chSel].offDelay, 6'h0, alarmDelay[chSel].onDelay};
					default: pslverr <= 1'b1;
				endcase
			end else if (paddr == PAE_ADDR_STAT) begin
				prdata <= {26'h0, rawAlarm, auxOutput};
			end else if (paddr == PAE_ADDR_OPT) begin
				prdata <= {29'h0, heatSync2};
			end else begin
				pslverr <= 1'b1;
			end
		end
	end

	// ****************************************
	// comparison, once per sample tick
	// ****************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rawAlarm <= 3'h0;
		end else if (sampleTick) begin
			for (int i = 0; i < PAE_CHANNELS; i++) begin
				logic signed [17:0] dev;
				logic signed [17:0] hiB;
				logic signed [17:0] loB;
				logic signed [17:0] hy;
				logic hit;
				dev = 18'(processValue) - 18'(setPoint);
				hiB = 18'(alarmLimit[i].hi);
				loB = -18'(alarmLimit[i].lo);
				hy = 18'(hysteresis);
				hit = 1'b0;
				case (baseType(alarmType[i]))
					PAE_OFF: hit = 1'b0;
					PAE_BAND: hit = (dev > hiB) || (dev < loB);
					PAE_DEV_HI: hit = dev > 18'(alarmValue[i]);
					PAE_DEV_LO: hit = dev < -18'(alarmValue[i]);
					PAE_RANGE: hit = (dev <= hiB) && (dev >= loB);
					PAE_ABS_HI: hit = processValue > alarmValue[i];
					PAE_ABS_LO: hit = processValue < alarmValue[i];
					PAE_LOOP_BURN: hit = (i == 0) && loopBurnout;
					PAE_RATE: hit = rateAlarm[i];
					PAE_RSP_HI: hit = rspSync2 && (remoteSetPoint > alarmValue[i]);
					PAE_RSP_LO: hit = rspSync2 && (remoteSetPoint < alarmValue[i]);
					default: hit = 1'b0;
				endcase
				if (alarmType[i] == PAE_BAND_SB && (hiB - hy) <= (loB + hy)) begin
					hit = 1'b0;
				end
				if (isStandby(alarmType[i]) && !standbyClear[i]) begin
					hit = 1'b0;
				end
				rawAlarm[i] <= hit;
			end
		end
	end

	// ****************************************
	// on and off delays, counted in seconds
	// ****************************************
	pae_state_t dlyState [PAE_CHANNELS];
	logic [9:0] dlyCount [PAE_CHANNELS];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < PAE_CHANNELS; i++) begin
				dlyState[i] <= PAE_IDLE;
				dlyCount[i] <= 10'h0;
			end
			delayedAlarm <= 3'h0;
		end else begin
			for (int i = 0; i < PAE_CHANNELS; i++) begin
				case (dlyState[i])
					PAE_IDLE: begin
						if (rawAlarm[i]) begin
							if (alarmDelay[i].onDelay == 10'h0) begin
								dlyState[i] <= PAE_ACTIVE;
								delayedAlarm[i] <= 1'b1;
							end else begin
								dlyState[i] <= PAE_ON_WAIT;
								dlyCount[i] <= alarmDelay[i].onDelay;
							end
						end
					end
					PAE_ON_WAIT: begin
						if (!rawAlarm[i]) begin
							dlyState[i] <= PAE_IDLE;
						end else if (secTick) begin
							if (dlyCount[i] == 10'h1) begin
								dlyState[i] <= PAE_ACTIVE;
								delayedAlarm[i] <= 1'b1;
							end
							dlyCount[i] <= dlyCount[i] - 10'h1;
						end
					end
					PAE_ACTIVE: begin
						if (!rawAlarm[i]) begin
							if (alarmDelay[i].offDelay == 10'h0) begin
								dlyState[i] <= PAE_IDLE;
								delayedAlarm[i] <= 1'b0;
							end else begin
								dlyState[i] <= PAE_OFF_WAIT;
								dlyCount[i] <= alarmDelay[i].offDelay;
							end
						end
					end
					PAE_OFF_WAIT: begin
						if (rawAlarm[i]) begin
							dlyState[i] <= PAE_ACTIVE;
						end else if (secTick) begin
							if (dlyCount[i] == 10'h1) begin
								dlyState[i] <= PAE_IDLE;
								delayedAlarm[i] <= 1'b0;
							end
							dlyCount[i] <= dlyCount[i] - 10'h1;
						end
					end
					default: dlyState[i] <= PAE_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// auxiliary outputs
	// ****************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			auxOutput <= 3'h0;
		end else begin
			auxOutput[0] <= delayedAlarm[0] || (optSync2 && (|heatSync2));
			auxOutput[2:1] <= delayedAlarm[2:1];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_type_reset: assert property (@(posedge clk) !reset_n |=> alarmType[1] == PAE_TYPE_RESET)
		else $error("alarm type not reset to default");
	a_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		sampleTick && alarmType[2] == PAE_OFF |=> !rawAlarm[2])
		else $error("type off raised alarm");
	a_abs_high: assert property (@(posedge clk) disable iff (!reset_n)
		sampleTick && alarmType[1] == PAE_ABS_HI && processValue > alarmValue[1] |=> rawAlarm[1])
		else $error("absolute high missed");
	a_abs_low: assert property (@(posedge clk) disable iff (!reset_n)
		sampleTick && alarmType[1] == PAE_ABS_LO && processValue >= alarmValue[1] |=> !rawAlarm[1])
		else $error("absolute low false alarm");
	a_heater_or: assert property (@(posedge clk) disable iff (!reset_n)
		optSync2 && heatSync2[0] |=> auxOutput[0])
		else $error("heater detection not on output");
	a_lba_chan: assert property (@(posedge clk) disable iff (!reset_n)
		alarmType[2] != PAE_LOOP_BURN && alarmType[1] != PAE_LOOP_BURN)
		else $error("loop burnout on wrong channel");
	a_zero_delay: assert property (@(posedge clk) disable iff (!reset_n)
		dlyState[1] == PAE_IDLE && rawAlarm[1] && alarmDelay[1].onDelay == 10'h0 ##1 rawAlarm[1]
		|=> auxOutput[1])
		else $error("zero on delay not immediate");
	a_dev_high: assert property (@(posedge clk) disable iff (!reset_n)
		sampleTick && alarmType[2] == PAE_DEV_HI && processValue - setPoint <= alarmValue[2]
		&& processValue - setPoint >= -16'sh100 |=> !rawAlarm[2])
		else $error("deviation high false alarm");
	a_sample_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!sampleTick |=> $stable(rawAlarm))
		else $error("compare changed without tick");
	a_band_overlap: assert property (@(posedge clk) disable iff (!reset_n)
		sampleTick && alarmType[0] == PAE_BAND_SB
		&& 18'(alarmLimit[0].hi) - 18'(hysteresis) <= 18'(hysteresis) - 18'(alarmLimit[0].lo) |=> !rawAlarm[0])
		else $error("overlapping band raised alarm");
	a_on_delay_hold: assert property (@(posedge clk) disable iff (!reset_n)
		dlyState[1] == PAE_ON_WAIT && !secTick |=> !auxOutput[1])
		else $error("output rose during on delay");
	a_heater_gate: assert property (@(posedge clk) disable iff (!reset_n)
		!optSync2 && !delayedAlarm[0] |=> !auxOutput[0])
		else $error("heater detection leaked without option");
	a_route_aux: assert property (@(posedge clk) disable iff (!reset_n)
		delayedAlarm[2] |=> auxOutput[2])
		else $error("alarm result not routed to output");
	a_standby_gate: assert property (@(posedge clk) disable iff (!reset_n)
		sampleTick && alarmType[0] == PAE_DEV_HI_SB && !standbyClear[0] |=> !rawAlarm[0])
		else $error("standby sequence did not hold alarm");
endmodule : pae_alarm

// ===== design/pae_pkg.sv
// Purpose: shared constants and carriers for the process alarm evaluator
// Assumes: signed 16-bit engineering values, 100 MHz clock
// Notes: register map offsets are byte addresses on APB
package pae_pkg;
	localparam int PAE_CHANNELS = 3;
	localparam int PAE_VAL_W = 16;
	localparam int PAE_DLY_W = 10;
	localparam int PAE_TYPE_W = 4;
	localparam logic [3:0] PAE_TYPE_RESET = 4'h2;
	localparam logic [9:0] PAE_DLY_MAX = 10'h3e7;
	localparam int PAE_CLK_HZ = 100000000;
	localparam int PAE_SEC_S = 1;
	localparam int PAE_SEC_CYCLES = PAE_CLK_HZ * PAE_SEC_S;
	// per channel block of four words at 0x10 stride
	localparam logic [11:0] PAE_CH_STRIDE = 12'h010;
	localparam logic [11:0] PAE_CH_BASE = 12'h000;
	localparam logic [3:0] PAE_OFS_CFG = 4'h0;
	localparam logic [3:0] PAE_OFS_VAL = 4'h4;
	localparam logic [3:0] PAE_OFS_LIM = 4'h8;
	localparam logic [3:0] PAE_OFS_DLY = 4'hc;
	localparam logic [11:0] PAE_ADDR_STAT = 12'h040;
	localparam logic [11:0] PAE_ADDR_OPT = 12'h044;
	localparam int PAE_DLY_ON_LSB = 0;
	localparam int PAE_DLY_OFF_LSB = 16;
	localparam int PAE_LIM_LO_LSB = 0;
	localparam int PAE_LIM_HI_LSB = 16;
	typedef enum logic [3:0] {
		PAE_OFF = 4'h0, PAE_BAND = 4'h1, PAE_DEV_HI = 4'h2, PAE_DEV_LO = 4'h3,
		PAE_RANGE = 4'h4, PAE_BAND_SB = 4'h5, PAE_DEV_HI_SB = 4'h6, PAE_DEV_LO_SB = 4'h7,
		PAE_ABS_HI = 4'h8, PAE_ABS_LO = 4'h9, PAE_ABS_HI_SB = 4'ha, PAE_ABS_LO_SB = 4'hb,
		PAE_LOOP_BURN = 4'hc, PAE_RATE = 4'hd, PAE_RSP_HI = 4'he, PAE_RSP_LO = 4'hf
	} pae_type_t;
	typedef struct packed {
		logic signed [15:0] hi;
		logic signed [15:0] lo;
	} pae_lim_t;
	typedef struct packed {
		logic [9:0] onDelay;
		logic [9:0] offDelay;
	} pae_dly_t;
	typedef enum {PAE_IDLE, PAE_ON_WAIT, PAE_ACTIVE, PAE_OFF_WAIT} pae_state_t;
endpackage : pae_pkg

// ===== tb/tb.sv
// Purpose: self-checking bench for the process alarm evaluator
// Assumes: zero on/off delays in random runs, small random hysteresis
// Notes: odd process values against even limits keep every process and deviation compare off its boundary
`timescale 1ns/1ns

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb;
	import pae_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sampleTick = 1'b0;
	logic signed [15:0] processValue = 16'h0;
	logic signed [15:0] setPoint = 16'h0;
	logic signed [15:0] remoteSetPoint = 16'h0;
	logic signed [15:0] hysteresis = 16'sh0;
	logic [2:0] standbyClear = 3'h0;
	logic loopBurnout = 1'b0;
	logic [2:0] rateAlarm = 3'h0;
	logic heaterBurnout = 1'b0;
	logic relayFailure = 1'b0;
	logic heaterOvercurrent = 1'b0;
	logic hasHeaterDetect = 1'b1;
	logic hasRemoteSetPoint = 1'b1;
	logic [2:0] auxOutput;
	logic [2:0] expAux;
	logic [2:0] expRaw;
	logic [3:0] t [3];
	int xv [3];
	int hv [3];
	int lv [3];
	int pv, sp, rsp, hy;
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 53;

	always #5 clk = ~clk;

	pae_alarm pae_alarm_i (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sampleTick(sampleTick), .processValue(processValue), .setPoint(setPoint),
		.remoteSetPoint(remoteSetPoint), .hysteresis(hysteresis), .standbyClear(standbyClear),
		.loopBurnout(loopBurnout), .rateAlarm(rateAlarm), .heaterBurnout(heaterBurnout),
		.relayFailure(relayFailure), .heaterOvercurrent(heaterOvercurrent),
		.hasHeaterDetect(hasHeaterDetect), .hasRemoteSetPoint(hasRemoteSetPoint), .auxOutput(auxOutput));

	// ****************************************
	// helpers
	// ****************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	function automatic logic [11:0] addr_of(int ch, logic [3:0] ofs);
		return PAE_CH_BASE + 12'(ch) * PAE_CH_STRIDE + {8'h00, ofs};
	endfunction : addr_of

	// one sample pulse, then time for the compare to reach the outputs
	task automatic pulse_tick();
		sampleTick <= 1'b1;
		@(posedge clk);
		sampleTick <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : pulse_tick

	function automatic int rv(int span);
		return ($random(seed) % span) * 2;
	endfunction : rv

	// expected comparison result of one channel, delays zero
	function automatic logic exp_alarm(logic [3:0] ty, int ch, int x, int hi, int lo, logic sb, logic lb, logic rt);
		int d;
		d = pv - sp;
		case (ty)
			4'h1: return (d > hi) || (d < -lo);
			4'h2: return d > x;
			4'h3: return d < -x;
			4'h4: return (d >= -lo) && (d <= hi);
			4'h5: return sb && !(hi - hy <= -lo + hy) && ((d > hi) || (d < -lo));
			4'h6: return sb && (d > x);
			4'h7: return sb && (d < -x);
			4'h8: return pv > x;
			4'h9: return pv < x;
			4'ha: return sb && (pv > x);
			4'hb: return sb && (pv < x);
			4'hc: return (ch == 0) && lb;
			4'hd: return rt;
			4'he: return rsp > x;
			4'hf: return rsp < x;
			default: return 1'b0;
		endcase
	endfunction : exp_alarm

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			n_mismatch++;
			final_report();
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex, input logic exErr);
		logic [31:0] r;
		logic e;
		apb(a, 1'b0, 32'h0, r, e);
		`CHK("read data", ex & m, r & m)
		`CHK("slave error", exErr, e)
	endtask : rdchk

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		`CHK("aux after reset", 3'h0, auxOutput)
		for (int ch = 0; ch < 3; ch++) begin
			rdchk(addr_of(ch, PAE_OFS_CFG), 32'hf, {28'h0, PAE_TYPE_RESET}, 1'b0);
		end
		rdchk(12'h030, 32'h0, 32'h0, 1'b1);
		rdchk(12'h048, 32'h0, 32'h0, 1'b1);
		wr(addr_of(1, PAE_OFS_CFG), 32'hc);
		rdchk(addr_of(1, PAE_OFS_CFG), 32'hf, 32'h2, 1'b0);
		wr(addr_of(0, PAE_OFS_CFG), 32'hc);
		rdchk(addr_of(0, PAE_OFS_CFG), 32'hf, 32'hc, 1'b0);
		hasRemoteSetPoint <= 1'b0;
		repeat (4) @(posedge clk);
		wr(addr_of(2, PAE_OFS_CFG), 32'he);
		rdchk(addr_of(2, PAE_OFS_CFG), 32'hf, 32'h2, 1'b0);
		hasRemoteSetPoint <= 1'b1;
		repeat (4) @(posedge clk);
		wr(addr_of(2, PAE_OFS_CFG), 32'he);
		rdchk(addr_of(2, PAE_OFS_CFG), 32'hf, 32'he, 1'b0);
		wr(addr_of(0, PAE_OFS_CFG), 32'h13);
		rdchk(addr_of(0, PAE_OFS_CFG), 32'hf, 32'h0, 1'b0);
		wr(addr_of(1, PAE_OFS_DLY), 32'h03ff_03e8);
		rdchk(addr_of(1, PAE_OFS_DLY), 32'h03ff_03ff, 32'h03e7_03e7, 1'b0);
		wr(addr_of(1, PAE_OFS_DLY), 32'h0);
		wr(addr_of(2, PAE_OFS_LIM), 32'h8001_7ffe);
		rdchk(addr_of(2, PAE_OFS_LIM), 32'hffff_ffff, 32'h8001_7ffe, 1'b0);
		// every type visits every channel over sixteen rounds, except loop burnout on channels 1 and 2
		for (int it = 0; it < 48; it++) begin
			for (int ch = 0; ch < 3; ch++) begin
				t[ch] = 4'((it + 5 * ch) % 16);
				if (ch != 0 && t[ch] == 4'hc) t[ch] = 4'hd;
				xv[ch] = rv(400);
				hv[ch] = rv(400);
				lv[ch] = rv(400);
				wr(addr_of(ch, PAE_OFS_CFG), {28'h0, t[ch]});
				wr(addr_of(ch, PAE_OFS_VAL), {16'h0, 16'(xv[ch])});
				wr(addr_of(ch, PAE_OFS_LIM), {16'(hv[ch]), 16'(lv[ch])});
			end
			pv = rv(800) + 1;
			sp = rv(400);
			rsp = rv(800);
			processValue <= 16'(pv);
			setPoint <= 16'(sp);
			remoteSetPoint <= 16'(rsp);
			standbyClear <= 3'($random(seed));
			loopBurnout <= 1'($random(seed));
			rateAlarm <= 3'($random(seed));
			heaterBurnout <= (($random(seed) & 7) == 0);
			relayFailure <= (($random(seed) & 7) == 0);
			heaterOvercurrent <= (($random(seed) & 7) == 0);
			hasHeaterDetect <= 1'($random(seed));
			hy = rv(50);
			if (hy < 0) hy = -hy;
			hysteresis <= 16'(hy);
			repeat (4) @(posedge clk);
			pulse_tick();
			for (int ch = 0; ch < 3; ch++) begin
				expRaw[ch] = exp_alarm(t[ch], ch, xv[ch], hv[ch], lv[ch], standbyClear[ch], loopBurnout, rateAlarm[ch]);
			end
			expAux = expRaw;
			expAux[0] = expRaw[0] | (hasHeaterDetect & (heaterBurnout | relayFailure | heaterOvercurrent));
			`CHK("aux outputs", expAux, auxOutput)
			rdchk(PAE_ADDR_STAT, 32'h3f, {26'h0, expRaw, expAux}, 1'b0);
			rdchk(PAE_ADDR_OPT, 32'h7, {29'h0, heaterOvercurrent, relayFailure, heaterBurnout}, 1'b0);
		end
		// nonzero on delay keeps the output low while the raw compare is high
		wr(addr_of(1, PAE_OFS_CFG), 32'h0);
		pulse_tick();
		wr(addr_of(1, PAE_OFS_VAL), 32'h0);
		wr(addr_of(1, PAE_OFS_DLY), 32'h0000_0001);
		wr(addr_of(1, PAE_OFS_CFG), 32'h8);
		processValue <= 16'sh0001;
		pulse_tick();
		repeat (20) @(posedge clk);
		`CHK("delayed aux", 1'b0, auxOutput[1])
		rdchk(PAE_ADDR_STAT, 32'h12, 32'h10, 1'b0);
		final_report();
	end
endmodule : tb
